// [verilog/adc_cfg_defs.vh]
// constants for the converter mode configuration port
`ifndef ADC_CFG_DEFS_VH
`define ADC_CFG_DEFS_VH

// serial word layout
`define WORD_BITS 5'd16
`define HEADER_BITS 5'd8
`define ADDR_WIDTH 7
`define DATA_WIDTH 8

// register offsets
`define OFS_SOFT_RESET 7'h00
`define OFS_POWER 7'h01
`define OFS_TIMING 7'h02
`define OFS_DRIVER 7'h03
`define OFS_FORMAT 7'h04

// reset values and implemented-bit masks
`define REG_RESET 8'h00
`define MASK_POWER 8'h03
`define MASK_TIMING 8'h0F
`define MASK_DRIVER 8'h7F
`define MASK_FORMAT 8'h3F

// field positions
`define SOFT_RESET_BIT 7
`define TIM_INV_BIT 3
`define TIM_DCS_BIT 0
`define DRV_TERM_BIT 3
`define DRV_TRI_BIT 2
`define FMT_ABP_BIT 2
`define FMT_SCRAMBLER_ENABLE_BIT 1
`define FMT_SIGNED_BIT 0

// field encodings
`define PWR_NORMAL 2'h0
`define PWR_NAP 2'h1
`define PWR_SLEEP 2'h3
`define FMT_CMOS_FULL 2'h0
`define FMT_LVDS_DDR 2'h1
`define FMT_CMOS_DDR 2'h2
`define TP_OFF 3'h0
`define TP_ZEROS 3'h1
`define TP_ONES 3'h3
`define TP_CHECKER 3'h5
`define TP_ALTERNATE 3'h7

// differential drive current, hundredths of a milliamp
`define DRV_CODE_3P5 10'h15E
`define DRV_CODE_4P0 10'h190
`define DRV_CODE_4P5 10'h1C2
`define DRV_CODE_3P0 10'h12C
`define DRV_CODE_2P5 10'h0FA
`define DRV_CODE_2P1 10'h0D2
`define DRV_CODE_1P75 10'h0AF
`define TERM_GAIN_NUM 14'h0010
`define TERM_GAIN_DEN 14'h000A

// sample word patterns, overrange flag in bit 12
`define PAT_CHECK_A 13'h1555
`define PAT_CHECK_B 13'h0AAA
`define PAT_ALL_ONES 13'h1FFF
`define PAT_ALL_ZEROS 13'h0000
`define ODD_BIT_MASK 12'hAAA
`define SIGN_BIT_MASK 12'h800

`endif

// [verilog/pin_sync.v]
// two-stage synchroniser for the four configuration pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
	// clock and reset
	input wire clk,
	input wire rstn,
	// pins and their synchronised copies
	input wire [3:0] pin_in,
	output reg [3:0] pin_sync_out
);

	reg [3:0] stage1;

	// stage1 feeds only stage2, never any logic
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// chip-select (bit 2) starts at its idle high level, so no frame opens at release
			stage1 <= 4'h4;
			pin_sync_out <= 4'h4;
		end else begin
			stage1 <= pin_in;
			pin_sync_out <= stage1;
		end
	end

endmodule // pin_sync

`default_nettype wire

// [verilog/sample_formatter.v]
// output word formatting: test patterns, signed format, scrambler, odd-bit inversion
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_defs.vh"

module sample_formatter (
	// clock and reset
	input wire clk,
	input wire rstn,
	// raw sample from the core
	input wire sample_valid,
	input wire [11:0] sample_data,
	input wire sample_overrange,
	// formatting controls
	input wire [2:0] test_pattern_field,
	input wire odd_bit_invert_enable,
	input wire scrambler_enable,
	input wire signed_format_select,
	// formatted sample
	output reg [11:0] out_data,
	output reg overrange_flag
);

	reg phase;
	reg [11:0] next_data;
	reg [12:0] pattern;

	always @* begin
		next_data = sample_data;
		// odd-bit inversion forces offset binary
		if (signed_format_select && !odd_bit_invert_enable)
			next_data = next_data ^ `SIGN_BIT_MASK; // RULE22 RULE25
		if (scrambler_enable)
			next_data = {next_data[11:1] ^ {11{next_data[0]}}, next_data[0]}; // RULE23
		if (odd_bit_invert_enable)
			next_data = next_data ^ `ODD_BIT_MASK; // RULE24
		case (test_pattern_field)
			`TP_ZEROS: pattern = `PAT_ALL_ZEROS;
			`TP_ONES: pattern = `PAT_ALL_ONES;
			`TP_CHECKER: pattern = phase ? `PAT_CHECK_B : `PAT_CHECK_A;
			`TP_ALTERNATE: pattern = phase ? `PAT_ALL_ONES : `PAT_ALL_ZEROS;
			default: pattern = {sample_overrange, next_data};
		endcase
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase <= 1'b0;
			out_data <= 12'h000;
			overrange_flag <= 1'b0;
		end else if (sample_valid) begin
			phase <= ~phase;
			// patterns win over every other formatting setting
			out_data <= pattern[11:0]; // RULE21 RULE26
			overrange_flag <= pattern[12];
		end
	end

endmodule // sample_formatter

`default_nettype wire

// [verilog/adc_mode_config_port.v]
// mode configuration port: pin-strap decode, serial register port and mode outputs
// Notes on behaviour
// RULE1: select pin high gives pin-strap mode; chip-select, clock, data-in become static inputs.
// RULE2: in pin-strap mode chip-select low turns duty stabilizer off, high on.
// RULE3: pin-strap clock low: full-rate CMOS; high: DDR LVDS, 3.5mA, no termination.
// RULE4: pin-strap data-in low runs normally; high puts the converter to sleep.
// RULE5: select pin low makes the four pins a serial register port.
// RULE6: transfer runs while chip-select low; only first 16 rising clock edges sample.
// RULE7: word is read/write flag, seven address bits, eight data bits, MSB first.
// RULE8: flag zero writes the data bits into the addressed register.
// RULE9: flag one reads the register out, leaves it unchanged, ignores data-in.
// RULE10: data-out is open-drain, only pulls low, never drives high.
// RULE11: writing one to bit 7 at address 0 clears all registers; bit self-clears.
// RULE12: host's first command after power-up must be the software reset write.
// RULE13: power field: 00 normal, 01 nap, 11 sleep, 10 unused.
// RULE14: timing bit 3 inverts output clock, bit 0 enables duty stabilizer.
// RULE15: timing bits 2-1 delay output clock 0, 45, 90 or 135 degrees.
// RULE16: host must enable duty stabilizer whenever it sets a non-zero clock delay.
// RULE17: drive field bits 6-4 pick LVDS current; code 011 unused.
// RULE18: termination bit enables internal termination and scales current by 1.6.
// RULE19: output-mode bit 2 puts all digital outputs in high impedance.
// RULE20: format field: 00 full-rate CMOS, 01 DDR LVDS, 10 DDR CMOS.
// RULE21: test field: 000 off, 001 zeros, 011 ones, 101 checker, 111 alternating.
// RULE22: format bit 2 odd-bit invert, bit 1 scrambler, bit 0 two's complement.
// RULE23: scrambler XORs every data bit above the LSB with the LSB.
// RULE24: odd-bit invert flips D1 to D11; even bits and flag untouched.
// RULE25: with odd-bit invert on, output stays offset binary.
// RULE26: an active test pattern overrides all other formatting settings.
// RULE27: read data leaves MSB first during the last eight clock periods.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_defs.vh"

module adc_mode_config_port (
	// clock and reset
	input wire clk,
	input wire rstn,
	// configuration pins
	input wire config_interface_select,
	input wire cs_n,
	input wire sck,
	input wire sdi,
	// open-drain data-out
	output reg sdo_out,
	output reg sdo_oe,
	// raw sample from the converter core
	input wire sample_valid,
	input wire [11:0] sample_data,
	input wire sample_overrange,
	// formatted sample
	output wire [11:0] out_data,
	output wire overrange_flag,
	// effective modes
	output reg [1:0] power_state_field,
	output reg output_clock_polarity_invert,
	output reg [1:0] output_clock_delay_field,
	output reg duty_stabilizer_enable,
	output reg [2:0] diff_drive_current_field,
	output reg internal_termination_enable,
	output reg [9:0] drive_current_centi_ma,
	output reg output_tristate,
	output reg [1:0] output_format_field,
	output reg [2:0] test_pattern_field,
	output reg odd_bit_invert_enable,
	output reg scrambler_enable,
	output reg signed_format_select,
	output reg strap_mode
);

	////////////////////////////////////////////////////////////////////////////
	// serial engine states

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_SHIFT = 2'h1;
	localparam [1:0] ST_HOLD = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// declarations

	wire [3:0] synced;
	wire sel_s;
	wire cs_n_s;
	wire sck_s;
	wire sdi_s;
	reg sck_d;
	wire sck_rise;
	wire sck_fall;

	reg [1:0] state;
	reg [1:0] next_state;
	reg [4:0] bit_count;
	reg [15:0] shift_in;
	reg [7:0] read_shift;
	reg read_active;

	reg [7:0] reg_power;
	reg [7:0] reg_timing;
	reg [7:0] reg_driver;
	reg [7:0] reg_format;

	wire [6:0] word_addr;
	wire [7:0] word_data;
	wire word_is_read;
	wire commit;

	reg [7:0] cfg_power;
	reg [7:0] cfg_timing;
	reg [7:0] cfg_driver;
	reg [7:0] cfg_format;

	////////////////////////////////////////////////////////////////////////////
	// functions

	// register readback; reset register and unmapped offsets read zero
	function [7:0] read_value;
		input [6:0] addr;
		input [7:0] p;
		input [7:0] t;
		input [7:0] d;
		input [7:0] f;
		begin
			case (addr)
				`OFS_POWER: read_value = p & `MASK_POWER;
				`OFS_TIMING: read_value = t & `MASK_TIMING;
				`OFS_DRIVER: read_value = d & `MASK_DRIVER;
				`OFS_FORMAT: read_value = f & `MASK_FORMAT;
				default: read_value = `REG_RESET;
			endcase
		end
	endfunction

	// differential current in hundredths of a mA, 1.6x with termination
	function [9:0] drive_current;
		input [2:0] code;
		input term;
		reg [9:0] base;
		reg [13:0] scaled;
		begin
			case (code)
				3'h0: base = `DRV_CODE_3P5;
				3'h1: base = `DRV_CODE_4P0;
				3'h2: base = `DRV_CODE_4P5;
				3'h4: base = `DRV_CODE_3P0;
				3'h5: base = `DRV_CODE_2P5;
				3'h6: base = `DRV_CODE_2P1;
				3'h7: base = `DRV_CODE_1P75;
				default: base = 10'h000; // RULE17
			endcase
			scaled = ({4'h0, base} * `TERM_GAIN_NUM) / `TERM_GAIN_DEN;
			drive_current = term ? scaled[9:0] : base; // RULE18
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and clock edges

	pin_sync u_pin_sync (
		.clk(clk),
		.rstn(rstn),
		.pin_in({config_interface_select, cs_n, sck, sdi}),
		.pin_sync_out(synced)
	);

	assign sel_s = synced[3];
	assign cs_n_s = synced[2];
	assign sck_s = synced[1];
	assign sdi_s = synced[0];

	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			sck_d <= 1'b0;
		else
			sck_d <= sck_s;
	end

	assign sck_rise = sck_s & ~sck_d;
	assign sck_fall = ~sck_s & sck_d;

	////////////////////////////////////////////////////////////////////////////
	// serial word framing

	// word as shifted in: flag, address, data
	assign word_is_read = shift_in[15]; // RULE7
	assign word_addr = shift_in[14:8];
	assign word_data = shift_in[7:0];
	// a write takes effect when chip-select rises after a full word
	assign commit = (state != ST_IDLE) && cs_n_s && (bit_count == `WORD_BITS) && !word_is_read;

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (!sel_s && !cs_n_s)
					next_state = ST_SHIFT; // RULE5 RULE6
			ST_SHIFT:
				if (cs_n_s || sel_s)
					next_state = ST_IDLE;
				else if (sck_rise && bit_count == `WORD_BITS - 5'd1)
					next_state = ST_HOLD;
			ST_HOLD:
				if (cs_n_s || sel_s)
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			bit_count <= 5'h00;
			shift_in <= 16'h0000;
		end else begin
			state <= next_state;
			if (state == ST_IDLE) begin
				bit_count <= 5'h00;
			end else if (state == ST_SHIFT && sck_rise) begin
				// edges past the sixteenth land in ST_HOLD and are ignored
				shift_in <= {shift_in[14:0], sdi_s}; // RULE6
				bit_count <= bit_count + 5'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// readback on the open-drain data-out

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			read_active <= 1'b0;
			read_shift <= 8'h00;
			sdo_out <= 1'b0;
			sdo_oe <= 1'b0;
		end else begin
			// the pin is only ever pulled low
			sdo_out <= 1'b0; // RULE10
			if (next_state == ST_IDLE) begin
				read_active <= 1'b0;
				sdo_oe <= 1'b0;
			end else if (state == ST_SHIFT && sck_rise && bit_count == `HEADER_BITS - 5'd1) begin
				// header complete on this edge; data-in bits that follow are ignored
				read_active <= shift_in[6]; // RULE9
				read_shift <= read_value({shift_in[5:0], sdi_s}, reg_power, reg_timing, reg_driver, reg_format);
			end else if (read_active && sck_fall && bit_count >= `HEADER_BITS && bit_count < `WORD_BITS) begin
				// change on the falling edge so the host samples a settled level
				sdo_oe <= ~read_shift[7]; // RULE27 RULE10
				read_shift <= {read_shift[6:0], 1'b0};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mode-control registers

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_power <= `REG_RESET;
			reg_timing <= `REG_RESET;
			reg_driver <= `REG_RESET;
			reg_format <= `REG_RESET;
		end else if (commit) begin
			case (word_addr) // RULE8
				`OFS_SOFT_RESET:
					// reset bit is not stored, so it reads and stays zero
					if (word_data[`SOFT_RESET_BIT]) begin
						reg_power <= `REG_RESET; // RULE11
						reg_timing <= `REG_RESET;
						reg_driver <= `REG_RESET;
						reg_format <= `REG_RESET;
					end
				`OFS_POWER: reg_power <= word_data & `MASK_POWER;
				`OFS_TIMING: reg_timing <= word_data & `MASK_TIMING;
				`OFS_DRIVER: reg_driver <= word_data & `MASK_DRIVER;
				`OFS_FORMAT: reg_format <= word_data & `MASK_FORMAT;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// effective configuration: pin straps or registers

	always @* begin
		cfg_power = reg_power;
		cfg_timing = reg_timing;
		cfg_driver = reg_driver;
		cfg_format = reg_format;
		if (sel_s) begin
			// straps reach only stabilizer, output mode and sleep
			cfg_timing = {7'h00, cs_n_s}; // RULE1 RULE2
			cfg_driver = {6'h00, sck_s ? `FMT_LVDS_DDR : `FMT_CMOS_FULL}; // RULE3
			cfg_power = {6'h00, sdi_s ? `PWR_SLEEP : `PWR_NORMAL}; // RULE4
			cfg_format = `REG_RESET;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			power_state_field <= `PWR_NORMAL;
			output_clock_polarity_invert <= 1'b0;
			output_clock_delay_field <= 2'h0;
			duty_stabilizer_enable <= 1'b0;
			diff_drive_current_field <= 3'h0;
			internal_termination_enable <= 1'b0;
			drive_current_centi_ma <= `DRV_CODE_3P5;
			output_tristate <= 1'b0;
			output_format_field <= `FMT_CMOS_FULL;
			test_pattern_field <= `TP_OFF;
			odd_bit_invert_enable <= 1'b0;
			scrambler_enable <= 1'b0;
			signed_format_select <= 1'b0;
			strap_mode <= 1'b0;
		end else begin
			// unused code 10 is passed through unchanged
			power_state_field <= cfg_power[1:0]; // RULE13
			output_clock_polarity_invert <= cfg_timing[`TIM_INV_BIT]; // RULE14
			output_clock_delay_field <= cfg_timing[2:1]; // RULE15
			duty_stabilizer_enable <= cfg_timing[`TIM_DCS_BIT]; // RULE14
			diff_drive_current_field <= cfg_driver[6:4]; // RULE17
			internal_termination_enable <= cfg_driver[`DRV_TERM_BIT]; // RULE18
			drive_current_centi_ma <= drive_current(cfg_driver[6:4], cfg_driver[`DRV_TERM_BIT]); // RULE18
			output_tristate <= cfg_driver[`DRV_TRI_BIT]; // RULE19
			output_format_field <= cfg_driver[1:0]; // RULE20
			test_pattern_field <= cfg_format[5:3]; // RULE21
			odd_bit_invert_enable <= cfg_format[`FMT_ABP_BIT]; // RULE22
			scrambler_enable <= cfg_format[`FMT_SCRAMBLER_ENABLE_BIT]; // RULE22
			signed_format_select <= cfg_format[`FMT_SIGNED_BIT]; // RULE22
			strap_mode <= sel_s; // RULE1 RULE5
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output word formatting

	sample_formatter u_sample_formatter (
		.clk(clk),
		.rstn(rstn),
		.sample_valid(sample_valid),
		.sample_data(sample_data),
		.sample_overrange(sample_overrange),
		.test_pattern_field(test_pattern_field),
		.odd_bit_invert_enable(odd_bit_invert_enable),
		.scrambler_enable(scrambler_enable),
		.signed_format_select(signed_format_select),
		.out_data(out_data),
		.overrange_flag(overrange_flag)
	);

endmodule // adc_mode_config_port

`default_nettype wire

// [tb/cfg_host_model.sv]
// host controller model driving the serial configuration pins
`timescale 1ns/1ps
`default_nettype none

module cfg_host_model (
	// pacing clock
	input wire logic clk,
	// serial pins
	output logic cs_n,
	output logic sck,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// link clock stands low outside frames; 6 + 7 falling edges give 130 ns, near 125 ns in whole cycles
	task automatic half(input int n);
		repeat (n) @(negedge clk);
	endtask

	// sends the low n bits of w, msb first; rd gathers data-out at rises 9 to 16
	task automatic xfer(input logic [19:0] w, input int n, output logic [7:0] rd);
		rd = 8'h00;
		half(1);
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			sdi = w[i];
			half(6);
			if (n - 1 - i >= 8 && n - 1 - i < 16) rd = {rd[6:0], sdo};
			sck = 1'b1;
			half(7);
			sck = 1'b0;
		end
		half(6);
		cs_n = 1'b1;
		// data-in no longer valid: show the inverse rather than a stale bit
		sdi = ~sdi;
		half(8);
	endtask
endmodule // cfg_host_model

`default_nettype wire

// [tb/adc_mode_config_port_sva.sv]
// assertions on the configuration port's pins, modes and sample path
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_defs.vh"

module adc_mode_config_port_sva (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// pins
	input wire logic config_interface_select,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	// sample path
	input wire logic sample_valid,
	input wire logic [11:0] sample_data,
	input wire logic sample_overrange,
	input wire logic [11:0] out_data,
	input wire logic overrange_flag,
	// modes
	input wire logic [1:0] power_state_field,
	input wire logic duty_stabilizer_enable,
	input wire logic [2:0] diff_drive_current_field,
	input wire logic internal_termination_enable,
	input wire logic [9:0] drive_current_centi_ma,
	input wire logic [1:0] output_format_field,
	input wire logic [2:0] test_pattern_field,
	input wire logic odd_bit_invert_enable,
	input wire logic scrambler_enable,
	input wire logic signed_format_select,
	input wire logic strap_mode
);
	logic [13:0] base_ma;
	logic [13:0] want_ma;
	logic [11:0] scr;

	always @* begin
		case (diff_drive_current_field)
			3'h0: base_ma = {4'h0, `DRV_CODE_3P5};
			3'h1: base_ma = {4'h0, `DRV_CODE_4P0};
			3'h2: base_ma = {4'h0, `DRV_CODE_4P5};
			3'h4: base_ma = {4'h0, `DRV_CODE_3P0};
			3'h5: base_ma = {4'h0, `DRV_CODE_2P5};
			3'h6: base_ma = {4'h0, `DRV_CODE_2P1};
			3'h7: base_ma = {4'h0, `DRV_CODE_1P75};
			default: base_ma = 14'h0000;
		endcase
	end
	assign want_ma = internal_termination_enable ? base_ma * `TERM_GAIN_NUM / `TERM_GAIN_DEN : base_ma;
	assign scr = sample_data ^ {{11{sample_data[0]}}, 1'b0};

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_sdo_pull_only: assert property (sdo_oe |-> !sdo_out) else $error("data-out driven high");
	a_sdo_idle_release: assert property (cs_n [*6] |-> !sdo_oe) else $error("data-out pulled while idle");
	a_strap_entry: assert property (config_interface_select [*5] |-> strap_mode) else $error("strap mode missed");
	a_serial_entry: assert property (!config_interface_select [*5] |-> !strap_mode) else $error("serial mode missed");
	a_strap_stabilizer: assert property ((strap_mode && $stable(cs_n)) [*6] |-> duty_stabilizer_enable == cs_n)
		else $error("strap stabilizer wrong");
	a_strap_outmode: assert property ((strap_mode && $stable(sck)) [*6] |->
		output_format_field == (sck ? `FMT_LVDS_DDR : `FMT_CMOS_FULL) && !internal_termination_enable)
		else $error("strap output mode wrong");
	a_strap_sleep: assert property ((strap_mode && $stable(sdi)) [*6] |->
		power_state_field == (sdi ? `PWR_SLEEP : `PWR_NORMAL)) else $error("strap power wrong");
	// a commit lands a few cycles after chip-select rises, so only long idle spans are quiet
	a_modes_quiet: assert property ((!config_interface_select && !strap_mode && cs_n) [*8] |=>
		$stable({power_state_field, output_format_field, test_pattern_field, diff_drive_current_field}))
		else $error("mode changed without a transfer");
	a_drive_current: assert property (drive_current_centi_ma == want_ma[9:0])
		else $error("drive current wrong");
	a_fixed_pattern: assert property (sample_valid && (test_pattern_field == `TP_ZEROS ||
		test_pattern_field == `TP_ONES) |=> {overrange_flag, out_data} ==
		($past(test_pattern_field) == `TP_ONES ? `PAT_ALL_ONES : `PAT_ALL_ZEROS)) else $error("pattern wrong");
	a_scrambler_out: assert property (sample_valid && scrambler_enable && test_pattern_field == `TP_OFF &&
		!odd_bit_invert_enable && !signed_format_select |=> out_data == $past(scr) &&
		overrange_flag == $past(sample_overrange)) else $error("scrambled word wrong");
endmodule // adc_mode_config_port_sva

bind adc_mode_config_port adc_mode_config_port_sva u_sva (.clk, .rstn, .config_interface_select, .cs_n, .sck,
	.sdi, .sdo_out, .sdo_oe, .sample_valid, .sample_data, .sample_overrange, .out_data, .overrange_flag,
	.power_state_field, .duty_stabilizer_enable, .diff_drive_current_field, .internal_termination_enable,
	.drive_current_centi_ma, .output_format_field, .test_pattern_field, .odd_bit_invert_enable,
	.scrambler_enable, .signed_format_select, .strap_mode);

`default_nettype wire

// [tb/adc_mode_config_port_tb_top.sv]
// self-checking bench for the mode configuration port
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_defs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch at %0t got %h exp %h", $time, g, e); end end

module adc_mode_config_port_tb_top;
	localparam logic [7:0] MASKS [0:5] = '{8'h00, `MASK_POWER, `MASK_TIMING, `MASK_DRIVER, `MASK_FORMAT, 8'h00};
	localparam logic [7:0] FMT [0:10] = '{8'h00, 8'h04, 8'h05, 8'h01, 8'h02, 8'h08, 8'h18, 8'h28, 8'h38, 8'h0F, 8'h1F};
	localparam logic [12:0] EXP_A [0:10] = '{13'h1123, 13'h1B89, 13'h1B89, 13'h1923, 13'h1EDD, 13'h0000, 13'h1FFF,
		13'h1555, 13'h0000, 13'h0000, 13'h1FFF};
	localparam logic [12:0] EXP_B [0:10] = '{13'h1123, 13'h1B89, 13'h1B89, 13'h1923, 13'h1EDD, 13'h0000, 13'h1FFF,
		13'h0AAA, 13'h1FFF, 13'h0000, 13'h1FFF};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic config_interface_select = 1'b0;
	logic strap_cs = 1'b0;
	logic strap_sck = 1'b0;
	logic strap_sdi = 1'b0;
	logic sample_valid = 1'b0;
	logic sample_overrange = 1'b0;
	logic [11:0] sample_data = 12'h000;
	int miscompares = 0;
	int check_count = 0;
	wire cs_n, sck, sdi, h_cs, h_sck, h_sdi, sdo, sdo_out, sdo_oe, overrange_flag, strap_mode;
	wire output_clock_polarity_invert, duty_stabilizer_enable, internal_termination_enable, output_tristate;
	wire odd_bit_invert_enable, scrambler_enable, signed_format_select;
	wire [1:0] power_state_field, output_clock_delay_field, output_format_field;
	wire [2:0] diff_drive_current_field, test_pattern_field;
	wire [9:0] drive_current_centi_ma;
	wire [11:0] out_data;

	// strap levels and host link share the same pins
	assign cs_n = config_interface_select ? strap_cs : h_cs;
	assign sck = config_interface_select ? strap_sck : h_sck;
	assign sdi = config_interface_select ? strap_sdi : h_sdi;
	// board pull-up on the open-drain line
	assign sdo = sdo_oe ? sdo_out : 1'b1;

	always #5 clk = ~clk;

	adc_mode_config_port dut (.clk, .rstn, .config_interface_select, .cs_n, .sck, .sdi, .sdo_out, .sdo_oe,
		.sample_valid, .sample_data, .sample_overrange, .out_data, .overrange_flag, .power_state_field,
		.output_clock_polarity_invert, .output_clock_delay_field, .duty_stabilizer_enable,
		.diff_drive_current_field, .internal_termination_enable, .drive_current_centi_ma, .output_tristate,
		.output_format_field, .test_pattern_field, .odd_bit_invert_enable, .scrambler_enable,
		.signed_format_select, .strap_mode);
	cfg_host_model host (.clk, .cs_n(h_cs), .sck(h_sck), .sdi(h_sdi), .sdo);

	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		host.xfer({4'h0, 1'b0, a, d}, 16, r);
	endtask

	// data-in bits are all ones during a read, which must not reach the register
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] r;
		host.xfer({4'h0, 1'b1, a, 8'hFF}, 16, r);
		`CHK(r, e)
	endtask

	task automatic smp(output logic [12:0] r);
		sample_valid = 1'b1;
		sample_data = 12'h123;
		sample_overrange = 1'b1;
		@(negedge clk);
		sample_valid = 1'b0;
		sample_overrange = 1'b0;
		@(negedge clk);
		r = {overrange_flag, out_data};
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// ends on all-low pins so leaving strap mode changes chip-select
	task automatic t_strap;
		config_interface_select = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			{strap_cs, strap_sck, strap_sdi} = i[2:0];
			repeat (8) @(negedge clk);
			`CHK(strap_mode, 1'b1)
			`CHK(duty_stabilizer_enable, strap_cs)
			`CHK(output_format_field, strap_sck ? `FMT_LVDS_DDR : `FMT_CMOS_FULL)
			`CHK(drive_current_centi_ma, `DRV_CODE_3P5)
			`CHK(power_state_field, strap_sdi ? `PWR_SLEEP : `PWR_NORMAL)
		end
		config_interface_select = 1'b0;
		repeat (8) @(negedge clk);
		`CHK(strap_mode, 1'b0)
	endtask

	task automatic t_regs;
		wr(`OFS_SOFT_RESET, 8'h80);
		for (int a = 0; a < 6; a++) rd_chk(a[6:0], `REG_RESET);
		`CHK(power_state_field, `PWR_NORMAL)
		for (int a = 1; a < 6; a++) wr(a[6:0], 8'hFF);
		for (int a = 0; a < 6; a++) rd_chk(a[6:0], MASKS[a]);
		`CHK({power_state_field, test_pattern_field, output_tristate}, {`PWR_SLEEP, 3'h7, 1'b1})
		wr(`OFS_SOFT_RESET, 8'h80);
		for (int a = 1; a < 5; a++) rd_chk(a[6:0], `REG_RESET);
		`CHK({power_state_field, test_pattern_field, output_tristate}, 6'h00)
		wr(`OFS_POWER, 8'h03);
		rd_chk(`OFS_POWER, 8'h03);
	endtask

	task automatic t_fields;
		logic [1:0] f;
		logic [7:0] r;
		for (int c = 0; c < 4; c++) if (c != 2) begin
			wr(`OFS_POWER, c[7:0]);
			`CHK(power_state_field, c[1:0])
		end
		for (int i = 0; i < 16; i++) begin
			f = i[1:0] == 2'h3 ? 2'h0 : i[1:0];
			wr(`OFS_DRIVER, {1'b0, i[2:0], i[3], 1'b0, f});
			`CHK({diff_drive_current_field, internal_termination_enable}, {i[2:0], i[3]})
			`CHK({output_tristate, output_format_field}, {1'b0, f})
		end
		wr(`OFS_TIMING, 8'h07);
		`CHK({output_clock_polarity_invert, output_clock_delay_field, duty_stabilizer_enable}, 4'h7)
		wr(`OFS_TIMING, 8'h0B);
		`CHK({output_clock_polarity_invert, output_clock_delay_field, duty_stabilizer_enable}, 4'hB)
		wr(`OFS_FORMAT, 8'h2E);
		`CHK({test_pattern_field, odd_bit_invert_enable, scrambler_enable, signed_format_select}, 6'h2E)
		// four spare rising edges after the word, then a word cut short
		host.xfer({1'b0, `OFS_POWER, 8'h01, 4'hF}, 20, r);
		`CHK(power_state_field, `PWR_NAP)
		host.xfer({8'h00, 1'b0, `OFS_POWER, 4'h3}, 12, r);
		`CHK(power_state_field, `PWR_NAP)
	endtask

	task automatic t_format;
		logic [12:0] r;
		for (int i = 0; i < 11; i++) begin
			wr(`OFS_FORMAT, FMT[i]);
			smp(r);
			`CHK(r, EXP_A[i])
			smp(r);
			`CHK(r, EXP_B[i])
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		t_strap;
		t_regs;
		t_fields;
		t_format;
		tally_and_finish;
	end

	// the whole run needs well under a fifth of this span
	initial begin
		#900000;
		miscompares++;
		tally_and_finish;
	end
endmodule // adc_mode_config_port_tb_top

`default_nettype wire
